// file: design/slc_map.svh
`ifndef SLC_MAP_SVH
`define SLC_MAP_SVH
// register indices; byte address is four times the index
`define SLC_IDX_LINK_CTRL   6'h04
`define SLC_IDX_DRV_CFG     6'h05
`define SLC_IDX_RSV_A       6'h06
`define SLC_IDX_RSV_B       6'h07
`define SLC_IDX_LINE_FAULT  6'h08
`define SLC_IDX_RSV_C       6'h0c
`define SLC_IDX_IRQ_STAT    6'h10
`define SLC_IDX_IRQ_EN      6'h11
`define SLC_IDX_IRQ_CLR     6'h12
// link_control fields
`define SLC_BIT_SER_EN      7
`define SLC_BIT_CFG_LINK    6
`define SLC_BIT_PATTERN     5
`define SLC_BIT_SLEEP       4
`define SLC_POS_IF_SEL      2
`define SLC_BIT_REV_EN      1
`define SLC_BIT_FWD_EN      0
// driver_config fields
`define SLC_BIT_ADDR_OMIT   7
`define SLC_BIT_PLL_BYPASS  6
`define SLC_POS_LEVEL       4
`define SLC_POS_EMPH        0
// line_fault_status fields
`define SLC_POS_NEG_FAULT   2
`define SLC_POS_POS_FAULT   0
// interrupt status bits
`define SLC_IRQ_LINK_CHG    0
`define SLC_IRQ_REV_READY   1
`define SLC_IRQ_NEG_CHG     2
`define SLC_IRQ_POS_CHG     3
// reset values and interface select codes
`define SLC_RST_LINK_CTRL   8'h03
`define SLC_RST_DRV_CFG     8'h70
`define SLC_RST_RSV_A       8'h40
`define SLC_RST_RSV_B       8'h22
`define SLC_RST_RSV_C       8'h70
`define SLC_RST_FAULT       2'h2
`define SLC_IF_I2C          2'h0
`define SLC_IF_UART         2'h1
// timing
`define SLC_CLK_MHZ         100
`define SLC_REV_BLACKOUT_US 350
`endif

// file: design/slc_pkg.sv
`default_nettype none
package slc_pkg;
   typedef enum logic [1:0] {
      APB_IDLE = 2'b01,
      APB_RESP = 2'b10
   } slc_apb_e;
   typedef logic [7:0] slc_byte_t;
   typedef logic [3:0] slc_irq_t;
endpackage
`default_nettype wire

// file: design/slc_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "slc_map.svh"
module slc_regs #(
   parameter int BLACKOUT_CYCLES = `SLC_REV_BLACKOUT_US * `SLC_CLK_MHZ
) (
   input  wire  logic       CLK,
   input  wire  logic       NRST,
   input  wire  logic       PSEL,
   input  wire  logic       PENABLE,
   input  wire  logic       PWRITE,
   input  wire  logic [7:0] PADDR,
   input  wire  logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire  logic       AUTO_START_STRAP,
   input  wire  logic       CONTROL_DIRECTION_STRAP,
   input  wire  logic [1:0] NEG_WIRE_FAULT,
   input  wire  logic [1:0] POS_WIRE_FAULT,
   output logic             SERIAL_LINK_ENABLE,
   output logic             CONFIG_LINK_ENABLE,
   output logic             PATTERN_TEST_ENABLE,
   output logic             SLEEP_MODE,
   output logic [1:0]       PERIPHERAL_IF_SELECT,
   output logic             I2C_BASE_ENABLE,
   output logic             UART_BASE_ENABLE,
   output logic             REVERSE_CHANNEL_ENABLE,
   output logic             FORWARD_CHANNEL_ENABLE,
   output logic             ADDRESS_OMIT_SELECT,
   output logic             FILTER_PLL_BYPASS,
   output logic [1:0]       OUTPUT_LEVEL_SELECT,
   output logic [3:0]       EMPHASIS_SELECT,
   output logic             IRQ
);

   localparam logic [15:0] BLACKOUT_LOAD = 16'(BLACKOUT_CYCLES);

   slc_pkg::slc_apb_e  apb_state_ff;
   slc_pkg::slc_byte_t link_ctrl_ff;
   slc_pkg::slc_byte_t drv_cfg_ff;
   slc_pkg::slc_byte_t rsv_a_ff;
   slc_pkg::slc_byte_t rsv_b_ff;
   slc_pkg::slc_byte_t rsv_c_ff;
   slc_pkg::slc_irq_t  irq_stat_ff;
   slc_pkg::slc_irq_t  irq_en_ff;
   slc_pkg::slc_irq_t  nxt_irq_stat;
   slc_pkg::slc_irq_t  irq_evt;
   logic [1:0]         neg_fault_ff;
   logic [1:0]         pos_fault_ff;
   logic               strap_done_ff;
   logic               ser_prev_ff;
   logic [15:0]        blackout_cnt_ff;
   logic               rev_en_ff;
   logic               i2c_en_ff;
   logic               uart_en_ff;
   logic               irq_ff;
   logic [31:0]        prdata_ff;
   logic               pready_ff;
   logic               pslverr_ff;
   logic               link_chg;
   logic               wr_fire;
   logic [5:0]         idx;

   // register index decode, shared by read and write paths
   function automatic logic is_mapped(input logic [5:0] a, input logic wr);
      if (a == `SLC_IDX_LINK_CTRL) begin
         return 1'b1;
      end else if (a == `SLC_IDX_DRV_CFG) begin
         return 1'b1;
      end else if (a == `SLC_IDX_RSV_A || a == `SLC_IDX_RSV_B) begin
         return 1'b1;
      end else if (a == `SLC_IDX_RSV_C || a == `SLC_IDX_IRQ_EN) begin
         return 1'b1;
      end else if (a == `SLC_IDX_LINE_FAULT || a == `SLC_IDX_IRQ_STAT) begin
         return !wr;
      end else if (a == `SLC_IDX_IRQ_CLR) begin
         return wr;
      end else begin
         return 1'b0;
      end
   endfunction

   assign idx     = PADDR[7:2];
   assign wr_fire = PSEL && PENABLE && pready_ff && PWRITE && !pslverr_ff;

   // apb slave: one wait state, answer registered
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         apb_state_ff <= slc_pkg::APB_IDLE;
         pready_ff    <= 1'b0;
         pslverr_ff   <= 1'b0;
         prdata_ff    <= 32'h0000_0000;
      end else begin
         case (apb_state_ff)
            slc_pkg::APB_IDLE: begin
               if (PSEL && PENABLE) begin
                  apb_state_ff <= slc_pkg::APB_RESP;
                  pready_ff    <= 1'b1;
                  pslverr_ff   <= !is_mapped(idx, PWRITE);
                  if (PWRITE) begin
                     prdata_ff <= 32'h0000_0000;
                  end else if (idx == `SLC_IDX_LINK_CTRL) begin
                     prdata_ff <= {24'h00_0000, link_ctrl_ff};
                  end else if (idx == `SLC_IDX_DRV_CFG) begin
                     prdata_ff <= {24'h00_0000, drv_cfg_ff};
                  end else if (idx == `SLC_IDX_RSV_A) begin
                     prdata_ff <= {24'h00_0000, rsv_a_ff};
                  end else if (idx == `SLC_IDX_RSV_B) begin
                     prdata_ff <= {24'h00_0000, rsv_b_ff};
                  end else if (idx == `SLC_IDX_LINE_FAULT) begin
                     prdata_ff <= {28'h000_0000, neg_fault_ff, pos_fault_ff};
                  end else if (idx == `SLC_IDX_RSV_C) begin
                     prdata_ff <= {24'h00_0000, rsv_c_ff};
                  end else if (idx == `SLC_IDX_IRQ_STAT) begin
                     prdata_ff <= {28'h000_0000, irq_stat_ff};
                  end else if (idx == `SLC_IDX_IRQ_EN) begin
                     prdata_ff <= {28'h000_0000, irq_en_ff};
                  end else begin
                     prdata_ff <= 32'h0000_0000;
                  end
               end
            end
            slc_pkg::APB_RESP: begin
               apb_state_ff <= slc_pkg::APB_IDLE;
               pready_ff    <= 1'b0;
               pslverr_ff   <= 1'b0;
            end
            default: begin
               apb_state_ff <= slc_pkg::APB_IDLE;
               pready_ff    <= 1'b0;
               pslverr_ff   <= 1'b0;
            end
         endcase
      end
   end

   // link control: strap defaults loaded once after reset release
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         link_ctrl_ff  <= `SLC_RST_LINK_CTRL;
         strap_done_ff <= 1'b0;
      end else if (!strap_done_ff) begin
         strap_done_ff <= 1'b1;
         link_ctrl_ff[`SLC_BIT_SER_EN] <= !AUTO_START_STRAP;
         link_ctrl_ff[`SLC_BIT_SLEEP]  <= CONTROL_DIRECTION_STRAP && AUTO_START_STRAP;
      end else if (wr_fire && idx == `SLC_IDX_LINK_CTRL) begin
         link_ctrl_ff <= PWDATA[7:0];
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         drv_cfg_ff <= `SLC_RST_DRV_CFG;
      end else if (wr_fire && idx == `SLC_IDX_DRV_CFG) begin
         drv_cfg_ff <= PWDATA[7:0];
      end
   end

   // reserved words keep whatever software leaves there
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rsv_a_ff <= `SLC_RST_RSV_A;
         rsv_b_ff <= `SLC_RST_RSV_B;
         rsv_c_ff <= `SLC_RST_RSV_C;
      end else if (wr_fire) begin
         if (idx == `SLC_IDX_RSV_A) begin
            rsv_a_ff <= PWDATA[7:0];
         end else if (idx == `SLC_IDX_RSV_B) begin
            rsv_b_ff <= PWDATA[7:0];
         end else if (idx == `SLC_IDX_RSV_C) begin
            rsv_c_ff <= PWDATA[7:0];
         end
      end
   end

   // line fault capture from the detector
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         neg_fault_ff <= `SLC_RST_FAULT;
         pos_fault_ff <= `SLC_RST_FAULT;
      end else begin
         neg_fault_ff <= NEG_WIRE_FAULT;
         pos_fault_ff <= POS_WIRE_FAULT;
      end
   end

   // reverse channel blackout after every link start or stop
   assign link_chg = link_ctrl_ff[`SLC_BIT_SER_EN] != ser_prev_ff;

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ser_prev_ff     <= 1'b0;
         blackout_cnt_ff <= 16'h0000;
      end else begin
         ser_prev_ff <= link_ctrl_ff[`SLC_BIT_SER_EN];
         if (link_chg) begin
            blackout_cnt_ff <= BLACKOUT_LOAD;
         end else if (blackout_cnt_ff != 16'h0000) begin
            blackout_cnt_ff <= blackout_cnt_ff - 16'h0001;
         end
      end
   end

   // decoded outputs held in flops
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rev_en_ff  <= 1'b0;
         i2c_en_ff  <= 1'b0;
         uart_en_ff <= 1'b0;
      end else begin
         rev_en_ff  <= link_ctrl_ff[`SLC_BIT_REV_EN] && !link_chg
                       && blackout_cnt_ff == 16'h0000;
         i2c_en_ff  <= link_ctrl_ff[3:2] == `SLC_IF_I2C;
         uart_en_ff <= link_ctrl_ff[3:2] == `SLC_IF_UART;
      end
   end

   // interrupt status: set wins over clear
   always_comb begin
      irq_evt = '0;
      irq_evt[`SLC_IRQ_LINK_CHG]  = link_chg;
      irq_evt[`SLC_IRQ_REV_READY] = blackout_cnt_ff == 16'h0001;
      irq_evt[`SLC_IRQ_NEG_CHG]   = neg_fault_ff != NEG_WIRE_FAULT;
      irq_evt[`SLC_IRQ_POS_CHG]   = pos_fault_ff != POS_WIRE_FAULT;
      nxt_irq_stat = irq_stat_ff;
      if (wr_fire && idx == `SLC_IDX_IRQ_CLR) begin
         nxt_irq_stat = irq_stat_ff & ~PWDATA[3:0];
      end
      nxt_irq_stat = nxt_irq_stat | irq_evt;
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         irq_stat_ff <= 4'h0;
         irq_en_ff   <= 4'h0;
         irq_ff      <= 1'b0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         if (wr_fire && idx == `SLC_IDX_IRQ_EN) begin
            irq_en_ff <= PWDATA[3:0];
         end
         irq_ff <= |(irq_stat_ff & irq_en_ff);
      end
   end

   assign PRDATA                 = prdata_ff;
   assign PREADY                 = pready_ff;
   assign PSLVERR                = pslverr_ff;
   assign SERIAL_LINK_ENABLE     = link_ctrl_ff[`SLC_BIT_SER_EN];
   assign CONFIG_LINK_ENABLE     = link_ctrl_ff[`SLC_BIT_CFG_LINK];
   assign PATTERN_TEST_ENABLE    = link_ctrl_ff[`SLC_BIT_PATTERN];
   assign SLEEP_MODE             = link_ctrl_ff[`SLC_BIT_SLEEP];
   assign PERIPHERAL_IF_SELECT   = link_ctrl_ff[3:2];
   assign I2C_BASE_ENABLE        = i2c_en_ff;
   assign UART_BASE_ENABLE       = uart_en_ff;
   assign REVERSE_CHANNEL_ENABLE = rev_en_ff;
   assign FORWARD_CHANNEL_ENABLE = link_ctrl_ff[`SLC_BIT_FWD_EN];
   assign ADDRESS_OMIT_SELECT    = drv_cfg_ff[`SLC_BIT_ADDR_OMIT];
   assign FILTER_PLL_BYPASS      = drv_cfg_ff[`SLC_BIT_PLL_BYPASS];
   assign OUTPUT_LEVEL_SELECT    = drv_cfg_ff[5:4];
   assign EMPHASIS_SELECT        = drv_cfg_ff[3:0];
   assign IRQ                    = irq_ff;

   logic wr_link;
   logic rd_fault;
   assign wr_link  = wr_fire && idx == `SLC_IDX_LINK_CTRL;
   assign rd_fault = PSEL && PENABLE && !PWRITE && apb_state_ff == slc_pkg::APB_IDLE
                     && idx == `SLC_IDX_LINE_FAULT;

   link_write_a: assert property (@(posedge CLK) disable iff (!NRST)
      wr_link |=> SERIAL_LINK_ENABLE == $past(PWDATA[7]))
      else $error("link enable does not follow write");

   strap_link_a: assert property (@(posedge CLK) disable iff (!NRST)
      $rose(strap_done_ff) |-> SERIAL_LINK_ENABLE == !$past(AUTO_START_STRAP))
      else $error("link enable power-up value wrong");

   rev_blackout_a: assert property (@(posedge CLK) disable iff (!NRST)
      link_chg |=> (!REVERSE_CHANNEL_ENABLE && blackout_cnt_ff == BLACKOUT_LOAD) [*1]
      ##1 !REVERSE_CHANNEL_ENABLE [*7])
      else $error("reverse channel open during blackout");

   strap_sleep_a: assert property (@(posedge CLK) disable iff (!NRST)
      $rose(strap_done_ff) |-> SLEEP_MODE ==
         ($past(CONTROL_DIRECTION_STRAP) && $past(AUTO_START_STRAP)))
      else $error("sleep power-up value wrong");

   if_select_a: assert property (@(posedge CLK) disable iff (!NRST)
      wr_link ##1 1'b1 |=> I2C_BASE_ENABLE == ($past(PWDATA[3:2], 2) == 2'h0)
         && UART_BASE_ENABLE == ($past(PWDATA[3:2], 2) == 2'h1))
      else $error("interface select decode wrong");

   rev_disable_a: assert property (@(posedge CLK) disable iff (!NRST)
      wr_link && !PWDATA[1] |=> ##1 !REVERSE_CHANNEL_ENABLE)
      else $error("reverse channel not disabled");

   fwd_write_a: assert property (@(posedge CLK) disable iff (!NRST)
      wr_link |=> FORWARD_CHANNEL_ENABLE == $past(PWDATA[0]))
      else $error("forward channel does not follow write");

   addr_omit_a: assert property (@(posedge CLK) disable iff (!NRST)
      wr_fire && idx == `SLC_IDX_DRV_CFG |=> ADDRESS_OMIT_SELECT == $past(PWDATA[7]))
      else $error("address omit does not follow write");

   neg_fault_a: assert property (@(posedge CLK) disable iff (!NRST)
      rd_fault |=> PREADY && PRDATA[3:2] == $past(neg_fault_ff) && PRDATA[7:4] == 4'h0)
      else $error("negative wire fault read wrong");

   pos_fault_a: assert property (@(posedge CLK) disable iff (!NRST)
      rd_fault |=> PREADY && PRDATA[1:0] == $past(pos_fault_ff))
      else $error("positive wire fault read wrong");

   ser_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
      strap_done_ff && !wr_link |=> $stable(SERIAL_LINK_ENABLE))
      else $error("link enable changed without a write");

   rev_idle_a: assert property (@(posedge CLK) disable iff (!NRST)
      blackout_cnt_ff != 16'h0000 |=> !REVERSE_CHANNEL_ENABLE)
      else $error("reverse channel open while blackout counts");

   sleep_write_a: assert property (@(posedge CLK) disable iff (!NRST)
      wr_link |=> SLEEP_MODE == $past(PWDATA[4]))
      else $error("sleep does not follow write");

   if_off_a: assert property (@(posedge CLK) disable iff (!NRST)
      link_ctrl_ff[3] |=> !I2C_BASE_ENABLE && !UART_BASE_ENABLE)
      else $error("base interface not disabled");

   rev_enable_a: assert property (@(posedge CLK) disable iff (!NRST)
      link_ctrl_ff[`SLC_BIT_REV_EN] && !link_chg && blackout_cnt_ff == 16'h0000
      |=> REVERSE_CHANNEL_ENABLE)
      else $error("reverse channel not enabled");

endmodule
`default_nettype wire

// file: test/slc_fault_model.sv
`timescale 1ns/10ps
`default_nettype none
// cable wire detector: presents the commanded code one edge later
module slc_fault_model (
   input  wire logic       clk,
   input  wire logic [1:0] neg_cmd,
   input  wire logic [1:0] pos_cmd,
   output logic [1:0]      neg_code,
   output logic [1:0]      pos_code
);
   always_ff @(posedge clk) begin
      neg_code <= neg_cmd;
      pos_code <= pos_cmd;
   end
endmodule
`default_nettype wire

// file: test/slc_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
module slc_regs_bench;
   localparam int BO = 20;
   logic        clk, nrst, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, d;
   logic        pready, pslverr, er;
   logic        auto_strap, cdir_strap;
   logic [1:0]  neg_cmd, pos_cmd, neg_code, pos_code, f;
   logic        ser, cfg, pat, slp, i2c, uart, rev, fwd, omit, byp, irq;
   logic [1:0]  ifsel, lvl;
   logic [3:0]  emph;
   int          errors, comparisons;
   logic [7:0]  ra [6] = '{8'h14, 8'h18, 8'h1c, 8'h20, 8'h30, 8'h44};
   logic [7:0]  rv [6] = '{8'h70, 8'h40, 8'h22, 8'h0a, 8'h70, 8'h00};

   slc_regs #(.BLACKOUT_CYCLES(BO)) slc_regs_i (
      .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .AUTO_START_STRAP(auto_strap), .CONTROL_DIRECTION_STRAP(cdir_strap),
      .NEG_WIRE_FAULT(neg_code), .POS_WIRE_FAULT(pos_code),
      .SERIAL_LINK_ENABLE(ser), .CONFIG_LINK_ENABLE(cfg), .PATTERN_TEST_ENABLE(pat),
      .SLEEP_MODE(slp), .PERIPHERAL_IF_SELECT(ifsel), .I2C_BASE_ENABLE(i2c),
      .UART_BASE_ENABLE(uart), .REVERSE_CHANNEL_ENABLE(rev),
      .FORWARD_CHANNEL_ENABLE(fwd), .ADDRESS_OMIT_SELECT(omit),
      .FILTER_PLL_BYPASS(byp), .OUTPUT_LEVEL_SELECT(lvl), .EMPHASIS_SELECT(emph),
      .IRQ(irq));

   slc_fault_model slc_fault_model_i (
      .clk(clk), .neg_cmd(neg_cmd), .pos_cmd(pos_cmd),
      .neg_code(neg_code), .pos_code(pos_code));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one transfer; setup starts at the next edge, released at the ready edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check(32'(n), 32'h2);
   endtask

   task automatic settle(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   // legal driver settings only: no do-not-use level or emphasis codes
   function automatic logic [7:0] drv_value(input logic [31:0] r);
      logic [3:0] e;
      e = r[3:0];
      if (e inside {4'h5, 4'h6, 4'h7})
         e = 4'h8;
      return {r[7:6], 2'(r[5:4] % 3 + 1), e};
   endfunction

   task automatic finish_test;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (6000) @(posedge clk);
      errors++;
      finish_test;
   end

   initial begin
      errors = 0;
      comparisons = 0;
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      neg_cmd = 2'h2;
      pos_cmd = 2'h2;
      auto_strap = 1'b0;
      cdir_strap = 1'b1;
      void'($urandom(54772));
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      settle(3);
      check(ser, 1'b1);
      check(slp, 1'b0);
      check(rev, 1'b0);
      check(fwd, 1'b1);
      apb(1'b0, 8'h10, 32'h0);
      check(rd, 32'h83);
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, ra[i], 32'h0);
         check(rd, {24'h0, rv[i]});
      end
      settle(BO + 6);
      check(rev, 1'b1);
      $display("test reset done");
      apb(1'b1, 8'h10, 32'h03);
      settle(2);
      check(ser, 1'b0);
      check(rev, 1'b0);
      settle(BO - 6);
      check(rev, 1'b0);
      settle(10);
      check(rev, 1'b1);
      $display("test blackout done");
      for (int i = 0; i < 8; i++) begin
         d = $urandom & 32'hf3;
         f = 2'(i % 4);
         d[3:2] = f;
         apb(1'b1, 8'h10, d);
         settle(2);
         check({ser, cfg, pat, slp, ifsel, fwd}, {d[7:2], d[0]});
         check({i2c, uart}, {f == 2'h0, f == 2'h1});
         apb(1'b0, 8'h10, 32'h0);
         check(rd, d);
      end
      for (int i = 0; i < 6; i++) begin
         d = {24'h0, drv_value($urandom)};
         apb(1'b1, 8'h14, d);
         settle(2);
         check({omit, byp, lvl, emph}, d[7:0]);
         apb(1'b0, 8'h14, 32'h0);
         check(rd, d);
      end
      $display("test fields done");
      for (int i = 0; i < 4; i++) begin
         neg_cmd <= 2'(i);
         pos_cmd <= 2'(3 - i);
         settle(3);
         apb(1'b0, 8'h20, 32'h0);
         check(rd, {28'h0, 2'(i), 2'(3 - i)});
      end
      $display("test line fault done");
      apb(1'b1, 8'h44, 32'h4);
      apb(1'b1, 8'h48, 32'hf);
      settle(2);
      check(irq, 1'b0);
      neg_cmd <= 2'h2;
      settle(4);
      check(irq, 1'b1);
      apb(1'b0, 8'h40, 32'h0);
      check(rd & 32'h4, 32'h4);
      apb(1'b1, 8'h48, 32'h4);
      settle(2);
      check(irq, 1'b0);
      apb(1'b1, 8'h44, 32'h0);
      pos_cmd <= 2'h1;
      settle(4);
      check(irq, 1'b0);
      apb(1'b1, 8'h44, 32'h8);
      settle(2);
      check(irq, 1'b1);
      $display("test interrupt done");
      apb(1'b0, 8'h3c, 32'h0);
      check(er, 1'b1);
      apb(1'b1, 8'h20, 32'h0);
      check(er, 1'b1);
      apb(1'b0, 8'h48, 32'h0);
      check(er, 1'b1);
      apb(1'b0, 8'h10, 32'h0);
      check(er, 1'b0);
      $display("test refusal done");
      // second reset with the auto-start strap high
      nrst <= 1'b0;
      auto_strap <= 1'b1;
      settle(2);
      check(ser, 1'b0);
      check(irq, 1'b0);
      @(posedge clk);
      nrst <= 1'b1;
      settle(3);
      check(ser, 1'b0);
      check(slp, 1'b1);
      check({i2c, uart}, 2'h2);
      check(rev, 1'b1);
      apb(1'b0, 8'h10, 32'h0);
      check(rd, 32'h13);
      $display("test strap reset done");
      finish_test;
   end
endmodule
`default_nettype wire
